// *** hdl/ebtc_pkg.sv ***
// Purpose: constants shared by the timer/counter block
// Assumes: 10 MHz instruction clock, classic wishbone slave
// Notes: offsets are byte addresses of aligned 32-bit words
package ebtc_pkg;
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] COUNT_OFS = 4'h0;
  localparam logic [3:0] CONFIG_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  // ----------------------------------------------------------------------
  // config field positions
  // ----------------------------------------------------------------------
  localparam int CLK_SRC_BIT = 5;
  localparam int EDGE_SEL_BIT = 4;
  localparam int PRE_ASSIGN_BIT = 3;
  localparam int RATIO_LSB = 0;
  localparam int RATIO_W = 3;
  // ----------------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h3F;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// *** hdl/ebtc_prescaler.sv ***
// Purpose: 8-bit divider stage ahead of the count register
// Assumes: tick is a per-cycle enable, held high every cycle in timer mode
// Notes: internal count is never visible to software
`timescale 1ns/100ps
module ebtc_prescaler #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic tick,
  input wire logic [2:0] ratio,
  // result
  output logic out_tick
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic [WIDTH-1:0] mask;
  logic wrap;

  // ratio n divides by 2^(n+1)
  always_comb begin
    mask = WIDTH'((9'h002 << ratio) - 9'h001);
    wrap = tick && ((cnt_reg & mask) == mask);
    cnt_next = cnt_reg;
    if (clear) begin
      cnt_next = '0;
    end else if (tick) begin
      cnt_next = wrap ? '0 : cnt_reg + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign out_tick = wrap && !clear;
endmodule

// *** hdl/ebtc_sync.sv ***
// Purpose: two-flop synchroniser for the external count pin
// Assumes: input asynchronous to the clock
// Notes: first flop is read only by the second
`timescale 1ns/100ps
module ebtc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic d,
  output logic q
);
  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule

// *** hdl/ebtc_top.sv ***
// Overview of operation
// - source bit clear selects instruction-cycle timer mode
// - timer mode without prescaler increments every cycle
// - count write inhibits increments for two cycles
// - source bit set selects external pin counting
// - counter mode advances on chosen pin edge
// - edge bit clear rising, set falling
// - prescaler serves counter or watchdog, never both
// - assign bit clear counter, set watchdog
// - prescaler count has no software access
// - prescaler offers 1:2 through 1:256 ratios
// - count register is 8-bit read/write
// - 8-bit divider sits between source and counter
// - count write clears prescaler when assigned
//
// Purpose: 8-bit timer/counter with shared prescaler, wishbone slave
// Assumes: classic wishbone, one-wait-state ack
// Notes: watchdog tick leaves on O_WDOG_TICK when prescaler is given away
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module ebtc_top (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [3:0] I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // pins and watchdog side
  input wire logic I_EXT_COUNT_INPUT,
  input wire logic I_WDOG_TICK,
  output logic O_WDOG_TICK
);
  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic req;
  logic wr_count;
  logic wr_config;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;

  assign req = I_WB_CYC && I_WB_STB && !ack_reg;
  assign wr_count = req && I_WB_WE && I_WB_SEL[0] &&
    (I_WB_ADR == ebtc_pkg::COUNT_OFS);
  assign wr_config = req && I_WB_WE && I_WB_SEL[0] &&
    (I_WB_ADR == ebtc_pkg::CONFIG_OFS);

  // ----------------------------------------------------------------------
  // configuration and count state
  // ----------------------------------------------------------------------
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] config_reg;
  logic [7:0] config_next;
  logic [1:0] inhibit_reg;
  logic [1:0] inhibit_next;
  logic pin_sync;
  logic pin_last_reg;
  logic pin_last_next;
  logic edge_tick;
  logic src_tick;
  logic pre_tick;
  logic pre_out;
  logic pre_clear;
  logic use_pre;
  logic inc;
  logic wdog_reg;
  logic wdog_next;

  assign use_pre = !config_reg[ebtc_pkg::PRE_ASSIGN_BIT];

  ebtc_sync u_sync (
    .clk(I_MCLK),
    .rst(I_RST),
    .d(I_EXT_COUNT_INPUT),
    .q(pin_sync)
  );

  always_comb begin
    pin_last_next = pin_sync;
    // edge bit clear counts rising, set counts falling
    if (config_reg[ebtc_pkg::EDGE_SEL_BIT]) begin
      edge_tick = pin_last_reg && !pin_sync;
    end else begin
      edge_tick = !pin_last_reg && pin_sync;
    end
    if (config_reg[ebtc_pkg::CLK_SRC_BIT]) begin
      src_tick = edge_tick;
    end else begin
      src_tick = 1'b1;
    end
  end

  // one divider; its input comes from counter or watchdog, never both
  assign pre_tick = use_pre ? src_tick : I_WDOG_TICK;
  assign pre_clear = wr_count && use_pre;

  ebtc_prescaler #(.WIDTH(8)) u_pre (
    .clk(I_MCLK),
    .rst(I_RST),
    .clear(pre_clear),
    .tick(pre_tick),
    .ratio(config_reg[ebtc_pkg::RATIO_LSB +: ebtc_pkg::RATIO_W]),
    .out_tick(pre_out)
  );

  always_comb begin
    inc = (use_pre ? pre_out : src_tick) && (inhibit_reg == 2'h0);
    count_next = count_reg;
    config_next = config_reg;
    inhibit_next = (inhibit_reg != 2'h0) ? inhibit_reg - 2'h1 : 2'h0;
    wdog_next = !use_pre ? pre_out : I_WDOG_TICK;
    if (wr_count) begin
      count_next = I_WB_DAT[7:0];
      inhibit_next = ebtc_pkg::INHIBIT_CYCLES;
    end else if (inc) begin
      count_next = count_reg + 8'h01;
    end
    if (wr_config) begin
      config_next = I_WB_DAT[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // read path and ack
  // ----------------------------------------------------------------------
  always_comb begin
    ack_next = req;
    rdat_next = rdat_reg;
    if (req) begin
      case (I_WB_ADR)
        ebtc_pkg::COUNT_OFS: rdat_next = {24'h000000, count_reg};
        ebtc_pkg::CONFIG_OFS: rdat_next = {24'h000000, config_reg};
        ebtc_pkg::STATUS_OFS: rdat_next = {29'h0000000, pin_sync,
          inhibit_reg};
        default: rdat_next = ebtc_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      count_reg <= ebtc_pkg::COUNT_RST;
      config_reg <= ebtc_pkg::CONFIG_RST;
      inhibit_reg <= 2'h0;
      pin_last_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      wdog_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      config_reg <= config_next;
      inhibit_reg <= inhibit_next;
      pin_last_reg <= pin_last_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      wdog_reg <= wdog_next;
    end
  end

  assign O_WB_ACK = ack_reg;
  assign O_WB_DAT = rdat_reg;
  assign O_WDOG_TICK = wdog_reg;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  sequence s_write_cnt;
    wr_count;
  endsequence
  sequence s_quiet2;
    $stable(count_reg) [*2];
  endsequence
  sequence s_fall_seen;
    pin_last_reg && !pin_sync;
  endsequence
  sequence s_inhibit_run;
    inhibit_reg == 2'h2 ##1 inhibit_reg == 2'h1 ##1 inhibit_reg == 2'h0;
  endsequence

  // ----------------------------------------------------------------------
  // count path
  // ----------------------------------------------------------------------
  // the loaded value shows one cycle later, then holds for two
  a_write_inhibit: assert property (
    s_write_cnt |=> ##1 s_quiet2)
    else $error("count moved during inhibit");

  a_inhibit_len: assert property (
    s_write_cnt |=> s_inhibit_run)
    else $error("inhibit did not run two cycles");

  a_inhibit_end: assert property (
    wr_count && !config_reg[5] && !use_pre |=> ##2 inc)
    else $error("timer did not resume after inhibit");

  a_write_load: assert property (
    wr_count |=> count_reg == $past(I_WB_DAT[7:0]))
    else $error("count write not stored");

  a_timer_inc: assert property (
    !wr_count && !config_reg[5] && !use_pre && inhibit_reg == 2'h0
    |=> count_reg == $past(count_reg) + 8'h01)
    else $error("timer did not increment");

  a_counter_hold: assert property (
    !wr_count && config_reg[5] && !edge_tick |=> $stable(count_reg))
    else $error("counter moved without edge");

  a_pin_count: assert property (
    config_reg[5] && !use_pre && edge_tick && !wr_count &&
    inhibit_reg == 2'h0 |=> count_reg == $past(count_reg) + 8'h01)
    else $error("pin edge not counted");

  a_pre_inc: assert property (
    use_pre && pre_out && !wr_count &&
    inhibit_reg == 2'h0 |=> count_reg == $past(count_reg) + 8'h01)
    else $error("prescaler output not counted");

  a_pre_gate: assert property (
    use_pre && !wr_count && !pre_out |=> $stable(count_reg))
    else $error("counter moved without prescaler output");

  // ----------------------------------------------------------------------
  // pin path
  // ----------------------------------------------------------------------
  a_edge_rise: assert property (
    !config_reg[4] && edge_tick |-> pin_sync && !pin_last_reg)
    else $error("wrong edge polarity");

  a_edge_fall: assert property (
    config_reg[4] && edge_tick |-> s_fall_seen)
    else $error("falling edge polarity wrong");

  // two flops between the pin and the edge detector, no fewer
  a_pin_sync: assert property (
    pin_sync == $past(I_EXT_COUNT_INPUT, 2))
    else $error("pin not seen through two flops");

  // ----------------------------------------------------------------------
  // prescaler and watchdog
  // ----------------------------------------------------------------------
  a_pre_clear: assert property (
    wr_count && use_pre |=> u_pre.cnt_reg == 8'h00)
    else $error("prescaler not cleared");

  a_pre_silent: assert property (
    !pre_tick && !pre_clear |=> $stable(u_pre.cnt_reg))
    else $error("prescaler moved without tick or clear");

  a_wdog_src: assert property (
    !use_pre && !I_WDOG_TICK |=> $stable(u_pre.cnt_reg))
    else $error("counter source reached watchdog prescaler");

  a_wdog_raw: assert property (
    use_pre |=> O_WDOG_TICK == $past(I_WDOG_TICK))
    else $error("watchdog tick not passed straight");

  a_wdog_pre: assert property (
    !use_pre && !pre_out |=> !O_WDOG_TICK)
    else $error("watchdog tick bypassed prescaler");

  a_ratio_min: assert property (
    config_reg[2:0] == 3'h0 && pre_out |=> !pre_out)
    else $error("1:2 ratio ticked twice in a row");

  a_ratio_max: assert property (
    !use_pre && config_reg[2:0] == 3'h7 && pre_out |-> u_pre.cnt_reg == 8'hFF)
    else $error("1:256 ratio ticked early");

  // ----------------------------------------------------------------------
  // bus side
  // ----------------------------------------------------------------------
  a_bus_ack: assert property (
    req |=> O_WB_ACK ##1 !O_WB_ACK)
    else $error("ack not one cycle");

  a_ack_idle: assert property (
    !req |=> !O_WB_ACK)
    else $error("ack without a request");

  a_read_count: assert property (
    req && !I_WB_WE && I_WB_ADR == ebtc_pkg::COUNT_OFS
    |=> O_WB_DAT == {24'h000000, $past(count_reg)})
    else $error("count read wrong");

  a_unmapped: assert property (
    req && !I_WB_WE && I_WB_ADR == 4'hC |=> O_WB_DAT == ebtc_pkg::UNMAPPED_DATA)
    else $error("unmapped read not zero");

  a_cfg_write: assert property (
    wr_config |=> config_reg == $past(I_WB_DAT[7:0]))
    else $error("config write not stored");

  a_cfg_hold: assert property (
    !wr_config |=> $stable(config_reg))
    else $error("config changed without write");

  a_sel_gate: assert property (
    req && I_WB_WE && !I_WB_SEL[0] && I_WB_ADR == ebtc_pkg::COUNT_OFS
    |=> inhibit_reg == 2'h0)
    else $error("count write taken without lane 0");
endmodule

// *** sim/ebtc_pin_model.sv ***
// Purpose: far side model, count pin and watchdog tick source
// Assumes: called from the bench, changes just after rising edges
// Notes: pin holds its level between calls, as a real source would
`timescale 1ns/100ps
module ebtc_pin_model (
  // clock
  input wire logic i_clk,
  // far side lines
  output logic o_pin,
  output logic o_wd_tick
);
  initial begin
    o_pin = 1'b0;
    o_wd_tick = 1'b0;
  end
  // slow toggles so the synchroniser sees every level
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (4) @(posedge i_clk);
      o_pin <= ~o_pin;
    end
  endtask
  // one-cycle ticks with an idle cycle between
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_wd_tick <= 1'b1;
      @(posedge i_clk);
      o_wd_tick <= 1'b0;
    end
  endtask
endmodule

// *** sim/eight_bit_timer_counter_prescaler_bench.sv ***
// Purpose: self-checking bench for the timer/counter
// Assumes: classic wishbone slave, ack one cycle after the take
// Notes: read results are checked from a queue by a watcher
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module eight_bit_timer_counter_prescaler_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [3:0] wsel = 4'hF;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, pin, wd_in, wd_out;
  logic [31:0] lfsr = 32'h0001_502E;
  logic [7:0] v, e;
  logic [7:0] expq[$];
  int fail_count = 0;
  int tests_run = 0;
  int wd_seen = 0;
  int cycles = 0;
  int k;
  always #50 clk = ~clk;
  ebtc_top u_dut (.I_MCLK(clk), .I_RST(rst), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_SEL(sel), .I_WB_ADR(adr),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_EXT_COUNT_INPUT(pin), .I_WDOG_TICK(wd_in), .O_WDOG_TICK(wd_out));
  ebtc_pin_model u_pin (.i_clk(clk), .o_pin(pin), .o_wd_tick(wd_in));
  // --------
  // helpers
  // --------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // waits for ack without a count: only the timeout ends a hang
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= wsel;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    expq.push_back(x);
    wb(1'b0, a, 8'h00);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
    if (wd_out === 1'b1)
      wd_seen++;
    if (ack === 1'b1 && we === 1'b0) begin
      e = expq.pop_front();
      `CHK(rdat, 32'(e))
    end
  end
  // --------
  // scenarios
  // --------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(ebtc_pkg::COUNT_OFS, ebtc_pkg::COUNT_RST);
    rd(ebtc_pkg::CONFIG_OFS, ebtc_pkg::CONFIG_RST);
    rd(4'hC, 8'h00);
    wr(ebtc_pkg::CONFIG_OFS, 8'h08);
    v = rnd();
    wr(ebtc_pkg::COUNT_OFS, v);
    rd(ebtc_pkg::COUNT_OFS, v);
    rd(ebtc_pkg::COUNT_OFS, v + 8'h03);
    // two full periods give exactly two ticks whatever the phase
    for (int n = 0; n < 8; n++) begin
      wr(ebtc_pkg::CONFIG_OFS, 8'h08 | 8'(n));
      wd_seen = 0;
      u_pin.tick(4 << n);
      repeat (3) @(posedge clk);
      `CHK(wd_seen, 2)
    end
    wr(ebtc_pkg::CONFIG_OFS, 8'h02);
    wr(ebtc_pkg::COUNT_OFS, 8'h00);
    wd_seen = 0;
    u_pin.tick(5);
    repeat (26) @(posedge clk);
    `CHK(wd_seen, 5)
    rd(ebtc_pkg::COUNT_OFS, 8'h04);
    // odd toggles end on the chosen edge, so both polarities give the same count
    v = rnd();
    k = 2 * int'(v[1:0]) + 1;
    wr(ebtc_pkg::CONFIG_OFS, 8'h28);
    wr(ebtc_pkg::COUNT_OFS, 8'h00);
    u_pin.toggle(k);
    repeat (6) @(posedge clk);
    rd(ebtc_pkg::COUNT_OFS, {6'h00, v[1:0]} + 8'h01);
    rd(ebtc_pkg::STATUS_OFS, 8'h04);
    wr(ebtc_pkg::CONFIG_OFS, 8'h38);
    wr(ebtc_pkg::COUNT_OFS, 8'h00);
    u_pin.toggle(k);
    repeat (6) @(posedge clk);
    rd(ebtc_pkg::COUNT_OFS, {6'h00, v[1:0]} + 8'h01);
    // lane 0 off: the write is acked but must not land
    wsel = 4'hE;
    wr(ebtc_pkg::COUNT_OFS, 8'h55);
    wsel = 4'hF;
    rd(ebtc_pkg::COUNT_OFS, {6'h00, v[1:0]} + 8'h01);
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule
